// ==== src/eisb_pkg.sv ====
// Constants, state enum and state structs of the serial memory bus front end
package eisb_pkg;
  localparam int SYS_CLK_HZ             = 25_000_000;
  localparam int LINK_CLK_PERIOD_NS     = 30;
  localparam int GLITCH_FILTER_WIDTH_NS = 50;
  // Samples a level must hold before it is believed; a 50 ns pulse spans at most two
  localparam int FILT_LEN               = GLITCH_FILTER_WIDTH_NS / LINK_CLK_PERIOD_NS + 2;
  localparam int INTERNAL_WRITE_TIME_MS = 5;
  localparam int INTERNAL_WRITE_CYC     = INTERNAL_WRITE_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int TIMER_W                = 17;
  localparam int BYTE_BITS              = 8;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_DEFAULT  = 4'h5;
  localparam logic [2:0] ADDR_PIN_USE_DEFAULT = 3'h7;
  localparam logic [1:0] FILT_LAST            = 2'(FILT_LEN - 1);
  localparam logic [3:0] LAST_BIT             = 4'(BYTE_BITS - 1);
  localparam logic [3:0] BITS_DONE            = 4'(BYTE_BITS);

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ACK_WAIT = 3'h3,
    ST_ACK      = 3'h2,
    ST_RX       = 3'h6,
    ST_TX       = 3'h7,
    ST_RD_ACK   = 3'h5,
    ST_SKIP     = 3'h4
  } eisb_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } eisb_byte_t;

  // Link domain state; index 0 of the line vectors is the clock line, 1 the data line
  typedef struct packed {
    logic [1:0]      meta;
    logic [1:0]      sync;
    logic [1:0]      flt;
    logic [1:0]      prev;
    logic [1:0][1:0] cnt;
    logic [2:0]      pinMeta;
    logic [2:0]      pinSync;
    logic            busyMeta;
    logic            busySync;
    logic            ackMeta;
    logic            ackSync;
    logic            ackPrev;
    eisb_state_t     state;
    logic [3:0]      bitCnt;
    logic [7:0]      shift;
    logic [7:0]      rxHold;
    logic            isRead;
    logic            gotData;
    logic            sdaOe;
    logic            sdaOut;
    logic            rxTog;
    logic            reqTog;
    logic            stopTog;
  } eisb_link_t;

  // System domain state
  typedef struct packed {
    logic [2:0]         rxS;
    logic [2:0]         reqS;
    logic [2:0]         stopS;
    logic               wpMeta;
    logic               wpSync;
    eisb_byte_t         rx;
    logic               rdReq;
    logic               rdPend;
    logic [7:0]         rdHold;
    logic               ackTog;
    logic               wrCommit;
    logic               busy;
    logic [TIMER_W-1:0] timer;
  } eisb_sys_t;
endpackage

// ==== src/eisb_front_end.sv ====
// Two-wire serial memory slave front end: pin filtering, framing, addressing, write timing
//
// Function
// - Commands only inside start...stop frames
// - Eight-bit bytes, each followed by acknowledge
// - Slave only; master owns clock and framing
// - Always watch for start; need start first
// - Data rise with clock high ends command
// - Internal write finishes within five milliseconds
// - Reject line pulses up to 50 ns
// - Unused address pins are ignored entirely
// - Data line two-way, clock line input only
// - Receiver acks low in ninth clock
// - Busy writing: ignore commands, never acknowledge
// - Type code and select pins must match
// - Write protect high blocks every rewrite
`timescale 1ns/10ps
`default_nettype none
module eisb_front_end
  import eisb_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE  = DEVICE_TYPE_DEFAULT,
  parameter logic [2:0] ADDR_PIN_USE = ADDR_PIN_USE_DEFAULT,
  parameter int         WRITE_CYC    = INTERNAL_WRITE_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                linkClk,
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output var  logic                sdaOut,
  output var  logic                sdaOe,
  input  wire logic                addr_select_pin_low,
  input  wire logic                addr_select_pin_mid,
  input  wire logic                addr_select_pin_high,
  input  wire logic                wpIn,
  output var  eisb_pkg::eisb_byte_t rxByte,
  output var  logic                rdReq,
  input  wire logic [7:0]          rdData,
  output var  logic                wrCommit,
  output var  logic                writeBusy
);
  import eisb_pkg::*;

  // Timer must be able to reach the programmed count
  if (WRITE_CYC < 1 || WRITE_CYC > (2**TIMER_W) - 1) begin : gBadCyc
    $error("WRITE_CYC out of range");
  end

  eisb_link_t lr;
  eisb_link_t ln;
  eisb_sys_t  sr;
  eisb_sys_t  sn;

  logic       sclF;
  logic       sdaF;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  logic [7:0] addrByte;
  logic       addrMatch;

  // Filtered line events, all taken from registered copies
  assign sclF      = lr.flt[0];
  assign sdaF      = lr.flt[1];
  assign sclRise   = sclF & ~lr.prev[0];
  assign sclFall   = ~sclF & lr.prev[0];
  assign startEv   = sclF & lr.prev[0] & lr.prev[1] & ~sdaF;
  assign stopEv    = sclF & lr.prev[0] & ~lr.prev[1] & sdaF;
  assign addrByte  = {lr.shift[6:0], sdaF};
  // Only used select pins take part in the compare
  assign addrMatch = (addrByte[7:4] == DEVICE_TYPE) &&
                     (((addrByte[3:1] ^ lr.pinSync) & ADDR_PIN_USE) == 3'h0) &&
                     !lr.busySync;

  // Link domain next state
  always_comb begin
    ln        = lr;
    ln.meta   = {sdaIn, sclIn};
    ln.sync   = lr.meta;
    ln.prev   = lr.flt;
    ln.sdaOut = 1'b0; // Open drain: only ever pulls low
    // Level is believed only after FILT_LEN equal samples
    for (int i = 0; i < 2; i++) begin
      if (lr.sync[i] != lr.flt[i]) begin
        if (lr.cnt[i] == FILT_LAST) begin
          ln.flt[i] = lr.sync[i];
          ln.cnt[i] = 2'h0;
        end else begin
          ln.cnt[i] = lr.cnt[i] + 2'h1;
        end
      end else begin
        ln.cnt[i] = 2'h0;
      end
    end
    ln.pinMeta  = {addr_select_pin_high, addr_select_pin_mid, addr_select_pin_low};
    ln.pinSync  = lr.pinMeta;
    ln.busyMeta = sr.busy;
    ln.busySync = lr.busyMeta;
    ln.ackMeta  = sr.ackTog;
    ln.ackSync  = lr.ackMeta;
    ln.ackPrev  = lr.ackSync;
    // Read byte arrives while the clock is high in the read/write bit (first byte) or the master ack bit; held stable by the sender
    if (lr.ackSync != lr.ackPrev) begin
      ln.shift = sr.rdHold;
    end
    if (startEv) begin
      ln.state  = ST_ADDR;
      ln.bitCnt = 4'h0;
      ln.sdaOe  = 1'b0;
      ln.gotData = 1'b0;
    end else if (stopEv) begin
      // A stop after written bytes hands the write to the system side
      if (lr.gotData) begin
        ln.stopTog = ~lr.stopTog;
      end
      ln.state   = ST_IDLE;
      ln.sdaOe   = 1'b0;
      ln.gotData = 1'b0;
    end else begin
      case (lr.state)
        ST_ADDR: begin
          if (sclRise) begin
            ln.shift  = addrByte;
            ln.bitCnt = lr.bitCnt + 4'h1;
            if (lr.bitCnt == LAST_BIT) begin
              if (addrMatch) begin
                ln.isRead = addrByte[0];
                ln.state  = ST_ACK_WAIT;
                if (addrByte[0]) begin
                  ln.reqTog = ~lr.reqTog;
                end
              end else begin
                ln.state = ST_SKIP;
              end
            end
          end
        end
        ST_ACK_WAIT: begin
          if (sclFall) begin
            ln.sdaOe = 1'b1;
            ln.state = ST_ACK;
          end
        end
        ST_ACK: begin
          // Second fall ends the ninth clock; release or start sending
          if (sclFall) begin
            ln.bitCnt = 4'h0;
            if (lr.isRead) begin
              ln.sdaOe = ~lr.shift[7];
              ln.state = ST_TX;
            end else begin
              ln.sdaOe = 1'b0;
              ln.state = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (sclRise) begin
            ln.shift  = addrByte;
            ln.bitCnt = lr.bitCnt + 4'h1;
            if (lr.bitCnt == LAST_BIT) begin
              ln.rxHold  = addrByte;
              ln.rxTog   = ~lr.rxTog;
              ln.gotData = 1'b1;
              ln.state   = ST_ACK_WAIT;
            end
          end
        end
        ST_TX: begin
          if (sclRise) begin
            ln.bitCnt = lr.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (lr.bitCnt == BITS_DONE) begin
              ln.sdaOe = 1'b0;
              ln.state = ST_RD_ACK;
            end else begin
              ln.shift = {lr.shift[6:0], 1'b0};
              ln.sdaOe = ~lr.shift[6];
            end
          end
        end
        ST_RD_ACK: begin
          // Master ack asks for the next byte, a nack ends the read
          if (sclRise) begin
            if (!sdaF) begin
              ln.reqTog = ~lr.reqTog;
              ln.state  = ST_ACK;
            end else begin
              ln.state = ST_SKIP;
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          ln.sdaOe = 1'b0;
        end
        default: begin
          ln.state = ST_IDLE;
          ln.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Link domain registers; clock line is only ever sampled, never driven
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      lr        <= '0;
      lr.meta   <= 2'h3;
      lr.sync   <= 2'h3;
      lr.flt    <= 2'h3;
      lr.prev   <= 2'h3;
      lr.state  <= ST_IDLE;
    end else begin
      lr <= ln;
    end
  end

  // System domain next state
  always_comb begin
    sn          = sr;
    sn.rxS      = {sr.rxS[1:0], lr.rxTog};
    sn.reqS     = {sr.reqS[1:0], lr.reqTog};
    sn.stopS    = {sr.stopS[1:0], lr.stopTog};
    sn.wpMeta   = wpIn;
    sn.wpSync   = sr.wpMeta;
    sn.rx.valid = 1'b0;
    sn.rdReq    = 1'b0;
    sn.wrCommit = 1'b0;
    sn.rdPend   = 1'b0;
    // Received byte is stable in the link hold register until the next byte ends
    if (sr.rxS[2] != sr.rxS[1]) begin
      sn.rx.valid = 1'b1;
      sn.rx.data  = lr.rxHold;
    end
    // Read data is taken at the edge that ends the request pulse, so the user keeps the next byte ready
    if (sr.reqS[2] != sr.reqS[1]) begin
      sn.rdReq  = 1'b1;
      sn.rdPend = 1'b1;
    end
    if (sr.rdPend) begin
      sn.rdHold = rdData;
      sn.ackTog = ~sr.ackTog;
    end
    // Protected device drops the write instead of programming
    if (sr.stopS[2] != sr.stopS[1] && !sr.wpSync && !sr.busy) begin
      sn.wrCommit = 1'b1;
      sn.busy     = 1'b1;
      sn.timer    = '0;
    end else if (sr.busy) begin
      if (sr.timer == TIMER_W'(WRITE_CYC - 1)) begin
        sn.busy = 1'b0;
      end else begin
        sn.timer = sr.timer + TIMER_W'(1);
      end
    end
  end

  // System domain registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr <= '0;
    end else begin
      sr <= sn;
    end
  end

  // Outputs straight from flip-flops
  assign sdaOut    = lr.sdaOut;
  assign sdaOe     = lr.sdaOe;
  assign rxByte    = sr.rx;
  assign rdReq     = sr.rdReq;
  assign wrCommit  = sr.wrCommit;
  assign writeBusy = sr.busy;
endmodule
`default_nettype wire

// ==== test/eisb_chk.sv ====
// Port checker for the serial memory bus front end
`timescale 1ns/10ps
`default_nettype none
module eisb_chk #(
  parameter int WRITE_CYC = 20
) (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 linkClk,
  input wire logic                 sclIn,
  input wire logic                 sdaOut,
  input wire logic                 sdaOe,
  input wire eisb_pkg::eisb_byte_t rxByte,
  input wire logic                 rdReq,
  input wire logic                 wrCommit,
  input wire logic                 writeBusy
);
  logic [16:0] busyCnt_reg;

  // Length of the current busy run; a stuck timer shows as an overrun
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busyCnt_reg <= 17'h0;
    else busyCnt_reg <= writeBusy ? busyCnt_reg + 17'h1 : 17'h0;
  end

  property p_od; @(posedge linkClk) disable iff (!rst_n) sdaOut == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_oeClk; @(posedge linkClk) disable iff (!rst_n) $changed(sdaOe) |-> !sclIn; endproperty
  a_oeClk: assert property (p_oeClk) else $error("data pin moved with clock high");
  property p_busyAck; @(posedge linkClk) disable iff (!rst_n) writeBusy [*4] |-> !$rose(sdaOe); endproperty
  a_busyAck: assert property (p_busyAck) else $error("ack while busy");
  property p_cmtBusy; @(posedge sys_clk) disable iff (!rst_n) wrCommit |=> writeBusy; endproperty
  a_cmtBusy: assert property (p_cmtBusy) else $error("commit without busy");
  property p_busyMax; @(posedge sys_clk) disable iff (!rst_n) busyCnt_reg <= WRITE_CYC; endproperty
  a_busyMax: assert property (p_busyMax) else $error("busy too long");
  property p_busyWhy;
    @(posedge sys_clk) disable iff (!rst_n) $rose(writeBusy) |-> wrCommit || $past(wrCommit);
  endproperty
  a_busyWhy: assert property (p_busyWhy) else $error("busy without commit");
  property p_rxPulse; @(posedge sys_clk) disable iff (!rst_n) rxByte.valid |=> !rxByte.valid; endproperty
  a_rxPulse: assert property (p_rxPulse) else $error("byte valid too long");
  property p_rdPulse; @(posedge sys_clk) disable iff (!rst_n) rdReq |=> !rdReq; endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read request too long");
  c_cmt: cover property (@(posedge sys_clk) wrCommit);
  c_rd: cover property (@(posedge sys_clk) rdReq);
  c_rx: cover property (@(posedge sys_clk) rxByte.valid);
endmodule
bind eisb_front_end eisb_chk #(.WRITE_CYC(WRITE_CYC)) eisb_chk_inst (.sys_clk, .rst_n, .linkClk, .sclIn,
  .sdaOut, .sdaOe, .rxByte, .rdReq, .wrCommit, .writeBusy);
`default_nettype wire

// ==== test/eisb_master.sv ====
// Behavioural two-wire bus master facing the front end
`timescale 1ns/10ps
`default_nettype none
module eisb_master (
  output var  logic scl,
  output var  logic pullLow,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  // One bit: data moves mid low phase, read at end of high (600 ns low, 400 ns high)
  task automatic bit_slot(input logic b, output logic r);
    #300 pullLow = !b;
    #300 scl = 1'b1;
    #400 r = sda;
    scl = 1'b0;
  endtask
  task automatic start_cond;
    pullLow = 1'b0;
    #300 scl = 1'b1;
    #300 pullLow = 1'b1;
    #300 scl = 1'b0;
  endtask
  // A 40 ns dip with clock high must not open a frame
  task automatic glitch;
    #300 pullLow = 1'b1;
    #40 pullLow = 1'b0;
    #300 scl = 1'b0;
  endtask
  task automatic stop_cond;
    pullLow = 1'b1;
    #300 scl = 1'b1;
    #300 pullLow = 1'b0;
    #600;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, ack);
  endtask
  task automatic recv_byte(input logic mAck, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      b[i] = r;
    end
    bit_slot(!mAck, r);
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the serial memory bus front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eisb_pkg::*;
  localparam int WCYC = 500;
  logic       sys_clk, rst_n, linkClk, scl, mLow, wpIn, rdReq, wrCommit, writeBusy, sdaOut, sdaOe, ack;
  logic [2:0] pins;
  logic [7:0] rdData, got;
  eisb_byte_t rxByte;
  int         n_fail, num_checks, nCommit;
  logic [7:0] rxQ[$];
  // Open-drain line with pull-up: high unless either side pulls it low
  wire        sda = !mLow && (sdaOe ? sdaOut : 1'b1);

  eisb_front_end #(.WRITE_CYC(WCYC)) eisb_front_end_inst (.sys_clk, .rst_n, .linkClk, .sclIn(scl), .sdaIn(sda),
    .sdaOut, .sdaOe, .addr_select_pin_low(pins[0]), .addr_select_pin_mid(pins[1]),
    .addr_select_pin_high(pins[2]), .wpIn, .rxByte, .rdReq, .rdData, .wrCommit, .writeBusy);
  eisb_master eisb_master_inst (.scl, .pullLow(mLow), .sda);

  always #20 sys_clk = ~sys_clk;
  always #15 linkClk = ~linkClk;
  // User side: gather bytes, count commits; the next read byte stands ready and steps after each request
  always @(posedge sys_clk) begin
    if (rxByte.valid === 1'b1) rxQ.push_back(rxByte.data);
    if (wrCommit === 1'b1) nCommit++;
    if (rdReq === 1'b1) rdData <= #1 rdData + 8'h01;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] addr(input logic [2:0] p, input logic rd);
    return {DEVICE_TYPE_DEFAULT, p, rd};
  endfunction
  task automatic t_glitch;
    rxQ.delete();
    eisb_master_inst.glitch();
    eisb_master_inst.send_byte(addr(pins, 1'b0), ack);
    chk({7'h0, ack}, 8'h01);
    eisb_master_inst.send_byte(8'h55, ack);
    eisb_master_inst.stop_cond();
    chk(8'(rxQ.size()), 8'h00);
  endtask
  task automatic t_write(input logic wp);
    rxQ.delete();
    nCommit = 0;
    @(posedge sys_clk) #1 wpIn = wp;
    eisb_master_inst.start_cond();
    eisb_master_inst.send_byte(addr(pins, 1'b0), ack);
    chk({7'h0, ack}, 8'h00);
    eisb_master_inst.send_byte(8'h12, ack);
    chk({7'h0, ack}, 8'h00);
    eisb_master_inst.send_byte(8'h9a, ack);
    chk({7'h0, ack}, 8'h00);
    eisb_master_inst.stop_cond();
    chk(8'(rxQ.size()), 8'h02);
    chk(rxQ[0], 8'h12);
    chk(rxQ[1], 8'h9a);
    chk(8'(nCommit), {7'h0, !wp});
    chk({7'h0, writeBusy}, {7'h0, !wp});
  endtask
  // Address during the write time is refused, then the write ends in time
  task automatic t_busy;
    eisb_master_inst.start_cond();
    eisb_master_inst.send_byte(addr(pins, 1'b0), ack);
    chk({7'h0, ack}, 8'h01);
    eisb_master_inst.stop_cond();
    for (int i = 0; i < WCYC && writeBusy !== 1'b0; i++) @(posedge sys_clk);
    chk({7'h0, writeBusy}, 8'h00);
  endtask
  task automatic t_reject;
    logic [7:0] bad[3];
    bad = '{{4'h3, pins, 1'b0}, addr(pins ^ 3'h1, 1'b0), addr(pins ^ 3'h4, 1'b1)};
    foreach (bad[i]) begin
      eisb_master_inst.start_cond();
      eisb_master_inst.send_byte(bad[i], ack);
      chk({7'h0, ack}, 8'h01);
      eisb_master_inst.stop_cond();
    end
  endtask
  task automatic t_read;
    logic [7:0] e;
    e = rdData;
    eisb_master_inst.start_cond();
    eisb_master_inst.send_byte(addr(pins, 1'b1), ack);
    chk({7'h0, ack}, 8'h00);
    eisb_master_inst.recv_byte(1'b1, got);
    chk(got, e);
    eisb_master_inst.recv_byte(1'b0, got);
    chk(got, e + 8'h01);
    eisb_master_inst.stop_cond();
  endtask
  initial begin
    sys_clk = 1'b0;
    linkClk = 1'b0;
    rst_n = 1'b0;
    wpIn = 1'b0;
    rdData = 8'h3c;
    pins = 3'h5;
    n_fail = 0;
    num_checks = 0;
    nCommit = 0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    t_glitch();
    t_write(1'b0);
    t_busy();
    t_write(1'b1);
    t_reject();
    t_read();
    summarize();
  end
  // Watchdog: the sequence needs well under a millisecond
  initial begin
    #2_000_000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
